// *** hdl/jtap_pkg.sv ***
/*
 * Shared constants and types for the boundary-scan test access port.
 * Assumes a system clock of 40 MHz and a separate test clock from the scan controller.
 */
package jtap_pkg;
    // Register widths.
    localparam int JTAP_IR_W = 4;
    localparam int JTAP_DR_W = 32;
    localparam int JTAP_BUF_W = 32;
    // Instruction encodings.
    localparam logic [3:0] JTAP_IR_IDCODE = 4'h1;
    localparam logic [3:0] JTAP_IR_USER = 4'h8;
    localparam logic [3:0] JTAP_IR_BYPASS = 4'hf;
    // Instruction register capture pattern, low two bits 01.
    localparam logic [3:0] JTAP_IR_CAPTURE = 4'h1;
    // Identity value; arbitrary neutral pattern.
    localparam logic [31:0] JTAP_ID_VALUE = 32'h0000_0001;
    // Sixteen-state controller, one-hot.
    typedef enum logic [15:0] {
        ST_RESET = 16'h0001, ST_IDLE = 16'h0002, ST_SEL_DR = 16'h0004, ST_CAP_DR = 16'h0008,
        ST_SH_DR = 16'h0010, ST_EX1_DR = 16'h0020, ST_PA_DR = 16'h0040, ST_EX2_DR = 16'h0080,
        ST_UP_DR = 16'h0100, ST_SEL_IR = 16'h0200, ST_CAP_IR = 16'h0400, ST_SH_IR = 16'h0800,
        ST_EX1_IR = 16'h1000, ST_PA_IR = 16'h2000, ST_EX2_IR = 16'h4000, ST_UP_IR = 16'h8000
    } jtap_state_t;
endpackage

// *** hdl/jtap_buf2.sv ***
/*
 * Two-entry buffer with valid and ready on both sides, single clock.
 * Assumes producer and consumer share clk and the synchronous active-low reset.
 */
`timescale 1ns/1ps
module jtap_buf2 (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [jtap_pkg::JTAP_BUF_W-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [jtap_pkg::JTAP_BUF_W-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    import jtap_pkg::*;
    logic [JTAP_BUF_W-1:0] mem_ff [2];
    logic [JTAP_BUF_W-1:0] nxt_mem [2];
    logic wptr_ff, rptr_ff, nxt_wptr, nxt_rptr;
    logic [1:0] cnt_ff, nxt_cnt;
    logic push, pop;

    // Handshakes come straight from the fill count so full and empty are exact.
    assign in_ready = (cnt_ff != 2'h2);
    assign out_valid = (cnt_ff != 2'h0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Next state of storage and pointers.
    always_comb begin
        nxt_mem = mem_ff;
        nxt_wptr = wptr_ff;
        nxt_rptr = rptr_ff;
        nxt_cnt = cnt_ff;
        if (push) begin
            nxt_mem[wptr_ff] = in_data;
            nxt_wptr = ~wptr_ff;
        end
        if (pop) begin
            nxt_rptr = ~rptr_ff;
        end
        if (push && !pop) begin
            nxt_cnt = cnt_ff + 2'h1;
        end else if (pop && !push) begin
            nxt_cnt = cnt_ff - 2'h1;
        end
    end

    // Register the buffer; out_data is a combinational read of the head entry.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wptr_ff <= 1'b0;
            rptr_ff <= 1'b0;
            cnt_ff <= 2'h0;
        end else begin
            wptr_ff <= nxt_wptr;
            rptr_ff <= nxt_rptr;
            cnt_ff <= nxt_cnt;
        end
        mem_ff <= nxt_mem;
    end

    // Head word taken from registered storage.
    assign out_data = mem_ff[rptr_ff];
endmodule

// *** hdl/jtap_port.sv ***
/*
 * Boundary-scan test access port: sixteen-state controller, instruction register,
 * bypass, identity and a user data register whose updates are passed to system logic.
 * Assumes the scan controller owns tck; tck may stop between scans.
 */
// Operation
// - Mode select and serial data are sampled on rising test-clock edges.
// - The selected register shifts out serially, the output changing on falling edges.
// - The serial output is undriven except while a shift is in progress.
// - The serial output is undriven while the output-float condition is active.
// - With test reset high the scan logic controls the port.
// - With test reset low the port sits in reset and ignores scan inputs.
// - Float condition arms when test reset falls while event pin zero is high and one low.
`timescale 1ns/1ps
module jtap_port (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic trst,
    input wire logic emulator_event_pin_zero,
    input wire logic emulator_event_pin_one,
    output logic tdo_out,
    output logic tdo_oe,
    output logic float_active,
    output logic scan_control,
    output logic [jtap_pkg::JTAP_DR_W-1:0] user_data,
    output logic user_valid,
    input wire logic user_ready,
    input wire logic [jtap_pkg::JTAP_DR_W-1:0] status_in
);
    import jtap_pkg::*;

    // Scan-side state lives on tck; trst clears all of it except the float, trst-delay and status flops.
    jtap_state_t st_ff, nxt_st;
    logic [JTAP_IR_W-1:0] ir_sh_ff, nxt_ir_sh, ir_ff, nxt_ir;
    logic [JTAP_DR_W-1:0] dr_ff, nxt_dr, usr_ff, nxt_usr;
    logic byp_ff, nxt_byp;
    logic tgl_ff, nxt_tgl;
    logic trst_d_ff, float_ff, nxt_float;
    logic tdo_ff, oe_ff;
    logic [JTAP_DR_W-1:0] stat_m_ff, stat_ff;
    logic sel_bypass, sel_id, sel_user, shift_bit;

    // Decode the current instruction; unknown codes fall back to bypass.
    always_comb begin
        sel_id = (ir_ff == JTAP_IR_IDCODE);
        sel_user = (ir_ff == JTAP_IR_USER);
        sel_bypass = !sel_id && !sel_user;
    end

    // Controller next state, steered by tms.
    // The default branch recovers from any illegal code by returning to reset.
    always_comb begin
        case (st_ff)
            ST_RESET: nxt_st = tms ? ST_RESET : ST_IDLE;
            ST_IDLE: nxt_st = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: nxt_st = tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: nxt_st = tms ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR: nxt_st = tms ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: nxt_st = tms ? ST_UP_DR : ST_PA_DR;
            ST_PA_DR: nxt_st = tms ? ST_EX2_DR : ST_PA_DR;
            ST_EX2_DR: nxt_st = tms ? ST_UP_DR : ST_SH_DR;
            ST_UP_DR: nxt_st = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: nxt_st = tms ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR: nxt_st = tms ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR: nxt_st = tms ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: nxt_st = tms ? ST_UP_IR : ST_PA_IR;
            ST_PA_IR: nxt_st = tms ? ST_EX2_IR : ST_PA_IR;
            ST_EX2_IR: nxt_st = tms ? ST_UP_IR : ST_SH_IR;
            ST_UP_IR: nxt_st = tms ? ST_SEL_DR : ST_IDLE;
            default: nxt_st = ST_RESET;
        endcase
    end

    // Capture, shift and update of the instruction and data paths.
    always_comb begin
        nxt_ir_sh = ir_sh_ff;
        nxt_ir = ir_ff;
        nxt_dr = dr_ff;
        nxt_byp = byp_ff;
        nxt_usr = usr_ff;
        nxt_tgl = tgl_ff;
        case (st_ff)
            ST_RESET: nxt_ir = JTAP_IR_IDCODE;
            ST_CAP_IR: nxt_ir_sh = JTAP_IR_CAPTURE;
            ST_SH_IR: nxt_ir_sh = {tdi, ir_sh_ff[JTAP_IR_W-1:1]};
            ST_UP_IR: nxt_ir = ir_sh_ff;
            ST_CAP_DR: begin
                nxt_byp = 1'b0;
                nxt_dr = sel_id ? JTAP_ID_VALUE : stat_ff;
            end
            ST_SH_DR: begin
                nxt_byp = tdi;
                nxt_dr = {tdi, dr_ff[JTAP_DR_W-1:1]};
            end
            ST_UP_DR: begin
                if (sel_user) begin
                    nxt_usr = dr_ff;
                    nxt_tgl = ~tgl_ff; // Event toggles across to clk domain.
                end
            end
            default: nxt_ir_sh = ir_sh_ff;
        endcase
    end

    // Rising-edge scan state; trst low holds everything in reset.
    always_ff @(posedge tck or negedge trst) begin
        if (!trst) begin
            st_ff <= ST_RESET;
            ir_sh_ff <= JTAP_IR_CAPTURE;
            ir_ff <= JTAP_IR_IDCODE;
            dr_ff <= '0;
            byp_ff <= 1'b0;
            usr_ff <= '0;
            tgl_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            ir_sh_ff <= nxt_ir_sh;
            ir_ff <= nxt_ir;
            dr_ff <= nxt_dr;
            byp_ff <= nxt_byp;
            usr_ff <= nxt_usr;
            tgl_ff <= nxt_tgl;
        end
    end

    // Serial bit presented by the selected register.
    // The instruction path takes priority in its own shift state.
    always_comb begin
        if (st_ff == ST_SH_IR) begin
            shift_bit = ir_sh_ff[0];
        end else if (sel_bypass) begin
            shift_bit = byp_ff;
        end else begin
            shift_bit = dr_ff[0];
        end
    end

    // Output timing: falling edge launches, so the controller samples a full half period later.
    always_ff @(negedge tck or negedge trst) begin
        if (!trst) begin
            tdo_ff <= 1'b0;
            oe_ff <= 1'b0;
        end else begin
            tdo_ff <= shift_bit;
            oe_ff <= (st_ff == ST_SH_DR) || (st_ff == ST_SH_IR);
        end
    end

    // Float condition: sampled at the first rising tck after trst falls, cleared at a rising tck with trst high.
    // Pin levels are taken at that edge; they sit still across it by the float protocol.
    always_comb begin
        nxt_float = float_ff;
        if (trst_d_ff && !trst) begin
            nxt_float = emulator_event_pin_zero && !emulator_event_pin_one;
        end else if (trst) begin
            nxt_float = 1'b0;
        end
    end

    // Raw trst and pins are only sampled at tck; trst release keeps the float armed until then.
    always_ff @(posedge tck) begin
        trst_d_ff <= trst;
        float_ff <= nxt_float;
    end

    // Pin-facing outputs; the enable also drops under the float condition.
    assign float_active = float_ff;
    assign tdo_out = tdo_ff;
    assign tdo_oe = oe_ff && !float_ff;

    // Status word crosses into tck domain through two flops; sampled only at capture.
    // It must be quasi-static: a change near capture may give a mixed word.
    always_ff @(posedge tck) begin
        stat_m_ff <= status_in;
        stat_ff <= stat_m_ff;
    end

    // System side: synchronise trst and the update toggle.
    logic trst_m_ff, trst_s_ff, tg_m_ff, tg_s_ff, tg_p_ff;
    logic nxt_tg_p, upd_pulse;
    // An edge of the synchronised toggle marks one new user word.
    always_comb begin
        upd_pulse = tg_s_ff ^ tg_p_ff;
        nxt_tg_p = tg_s_ff;
    end
    // Both synchronisers clear on the system reset so no stale toggle fires a push.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            trst_m_ff <= 1'b0;
            trst_s_ff <= 1'b0;
            tg_m_ff <= 1'b0;
            tg_s_ff <= 1'b0;
            tg_p_ff <= 1'b0;
        end else begin
            trst_m_ff <= trst;
            trst_s_ff <= trst_m_ff;
            tg_m_ff <= tgl_ff;
            tg_s_ff <= tg_m_ff;
            tg_p_ff <= nxt_tg_p;
        end
    end
    // Scan control follows trst two clk edges late.
    assign scan_control = trst_s_ff;

    // The user word is stable for many clk cycles after its toggle, so it is read directly.
    // A word that arrives while the buffer is full is dropped; the scan side cannot stall.
    // The ready output is left open since a refused word cannot be retried.
    jtap_buf2 u_buf (
        .clk(clk),
        .reset_n(reset_n),
        .in_data(usr_ff),
        .in_valid(upd_pulse),
        .in_ready(),
        .out_data(user_data),
        .out_valid(user_valid),
        .out_ready(user_ready)
    );
endmodule

// *** bench/jtap_port_properties.sv ***
/* Concurrent checks on the test access port pins and user stream.
   Assumes it is bound to jtap_port and sees only its ports. */
`timescale 1ns/1ps
module jtap_port_properties (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic tck,
    input wire logic trst,
    input wire logic emulator_event_pin_zero,
    input wire logic emulator_event_pin_one,
    input wire logic tdo_out,
    input wire logic tdo_oe,
    input wire logic float_active,
    input wire logic scan_control,
    input wire logic [jtap_pkg::JTAP_DR_W-1:0] user_data,
    input wire logic user_valid,
    input wire logic user_ready
);
    import jtap_pkg::*;
    // Pin release; sampled on clk since tck may stand still.
    property p_float_oe; @(posedge clk) disable iff (!reset_n) float_active |-> !tdo_oe;
    endproperty
    a_float_oe: assert property (p_float_oe) else $error("tdo driven while floating");
    property p_trst_oe; @(posedge clk) disable iff (!reset_n) !trst |-> !tdo_oe;
    endproperty
    a_trst_oe: assert property (p_trst_oe) else $error("tdo driven in test reset");
    // Any output change must follow a falling tck; tck low outlasts a clk period.
    property p_tdo_fall; @(posedge clk) disable iff (!reset_n)
        trst && $past(trst) && $changed(tdo_out) |-> !tck;
    endproperty
    a_tdo_fall: assert property (p_tdo_fall) else $error("tdo moved off falling tck");
    property p_oe_rise; @(posedge clk) disable iff (!reset_n) $rose(tdo_oe) |-> !tck;
    endproperty
    a_oe_rise: assert property (p_oe_rise) else $error("tdo enabled off falling tck");
    // Two synchroniser flops, so three stable samples settle the level.
    property p_scan_hi; @(posedge clk) disable iff (!reset_n) trst [*3] |-> scan_control;
    endproperty
    a_scan_hi: assert property (p_scan_hi) else $error("scan control missing");
    property p_scan_lo; @(posedge clk) disable iff (!reset_n) (!trst) [*3] |-> !scan_control;
    endproperty
    a_scan_lo: assert property (p_scan_lo) else $error("scan control stuck");
    // The float flag lives on tck, which trst does not reset.
    property p_float_arm; @(posedge tck) disable iff (!reset_n)
        $fell(trst) && emulator_event_pin_zero && !emulator_event_pin_one |=> float_active;
    endproperty
    a_float_arm: assert property (p_float_arm) else $error("float not armed");
    property p_float_clr; @(posedge tck) disable iff (!reset_n) trst |=> !float_active;
    endproperty
    a_float_clr: assert property (p_float_clr) else $error("float not cleared");
    property p_user_hold; @(posedge clk) disable iff (!reset_n)
        user_valid && !user_ready |=> user_valid && $stable(user_data);
    endproperty
    a_user_hold: assert property (p_user_hold) else $error("user word lost in stall");
    c_word: cover property (@(posedge clk) $rose(user_valid));
    c_float: cover property (@(posedge clk) $rose(float_active));
    c_drive: cover property (@(posedge clk) $rose(tdo_oe));
endmodule
bind jtap_port jtap_port_properties u_props (.clk(clk), .reset_n(reset_n), .tck(tck),
    .trst(trst), .emulator_event_pin_zero(emulator_event_pin_zero),
    .emulator_event_pin_one(emulator_event_pin_one), .tdo_out(tdo_out), .tdo_oe(tdo_oe),
    .float_active(float_active), .scan_control(scan_control), .user_data(user_data),
    .user_valid(user_valid), .user_ready(user_ready));

// *** bench/jtap_scan_ctrl.sv ***
/* Behavioural scan controller owning the test clock and scan pins.
   Assumes tdo_w is the resolved test output wire. */
`timescale 1ns/1ps
module jtap_scan_ctrl (
    output logic tck,
    output logic tms,
    output logic tdi,
    output logic trst,
    output logic ev_zero,
    output logic ev_one,
    input wire logic tdo_w
);
    // Pulled levels at power-up; the clock stands low between frames.
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
        trst = 1'b0;
        ev_zero = 1'b0;
        ev_one = 1'b1;
        // One pulse with test reset low clears the scan logic even if the time-zero
        // edge of trst is missed.
        #20 tck = 1'b1;
        #32 tck = 1'b0;
    end
    task automatic pins(input logic t, input logic e0, input logic e1);
        trst = t;
        ev_zero = e0;
        ev_one = e1;
    endtask
    // One period: inputs move after the falling edge, tdo is taken at the rising edge.
    task automatic tick(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        #32 o = tdo_w;
        tck = 1'b1;
        #32 tck = 1'b0;
    endtask
    // From idle: select, capture, shift n bits LSB first, update, back to idle.
    task automatic scan(input logic ir, input logic [31:0] din, input int n,
        output logic [31:0] dout);
        logic o;
        dout = '0;
        tick(1'b1, 1'b1, o);
        if (ir) tick(1'b1, 1'b1, o);
        tick(1'b0, 1'b1, o);
        tick(1'b0, 1'b1, o);
        for (int i = 0; i < n; i++) tick(i == n - 1, din[i], dout[i]);
        tick(1'b1, 1'b1, o);
        tick(1'b0, 1'b1, o);
    endtask
endmodule

// *** bench/jtap_port_tb_top.sv ***
/* Self-checking bench for the test access port.
   Assumes the bound checker and the scan controller model beside it. */
`timescale 1ns/1ps
module jtap_port_tb_top;
    import jtap_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic user_ready = 1'b0;
    logic [JTAP_DR_W-1:0] status_in = 32'h5a3c_96e1;
    logic tck, tms, tdi, trst, ev_zero, ev_one, tdo_out, tdo_oe, float_active;
    logic scan_control, user_valid;
    logic [JTAP_DR_W-1:0] user_data;
    wire tdo_w;
    int err_count = 0;
    int compares = 0;
    assign tdo_w = tdo_oe ? tdo_out : 1'bz;
    always #12.5 clk = ~clk;
    jtap_port u_jtap_port (.clk(clk), .reset_n(reset_n), .tck(tck), .tms(tms), .tdi(tdi),
        .trst(trst), .emulator_event_pin_zero(ev_zero), .emulator_event_pin_one(ev_one),
        .tdo_out(tdo_out), .tdo_oe(tdo_oe), .float_active(float_active),
        .scan_control(scan_control), .user_data(user_data), .user_valid(user_valid),
        .user_ready(user_ready), .status_in(status_in));
    jtap_scan_ctrl u_jtap_scan_ctrl (.tck(tck), .tms(tms), .tdi(tdi), .trst(trst),
        .ev_zero(ev_zero), .ev_one(ev_one), .tdo_w(tdo_w));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude();
        if (err_count == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic t_ident();
        logic [31:0] d;
        logic o;
        u_jtap_scan_ctrl.pins(1'b1, 1'b0, 1'b1);
        repeat (6) u_jtap_scan_ctrl.tick(1'b1, 1'b1, o);
        u_jtap_scan_ctrl.tick(1'b0, 1'b1, o);
        u_jtap_scan_ctrl.tick(1'b0, 1'b1, o);
        check("idle tdo", o, 1'bz);
        u_jtap_scan_ctrl.scan(1'b0, '1, 32, d);
        check("identity", d, JTAP_ID_VALUE);
        check("scan control", scan_control, 1'b1);
        u_jtap_scan_ctrl.scan(1'b1, JTAP_IR_BYPASS, 4, d);
        check("ir capture", d[3:0], JTAP_IR_CAPTURE);
        // Bypass delays by one bit and captures a zero first.
        u_jtap_scan_ctrl.scan(1'b0, 32'h0000_00b5, 8, d);
        check("bypass", d[7:0], 8'h6a);
    endtask
    // Three updates against a stalled sink: two fit, the third is refused.
    task automatic t_user();
        logic [31:0] d;
        u_jtap_scan_ctrl.scan(1'b1, JTAP_IR_USER, 4, d);
        u_jtap_scan_ctrl.scan(1'b0, 32'hc3a5_0f1e, 32, d);
        check("status", d, status_in);
        u_jtap_scan_ctrl.scan(1'b0, 32'h1234_abcd, 32, d);
        u_jtap_scan_ctrl.scan(1'b0, 32'h0f0f_7777, 32, d);
        repeat (20) @(negedge clk);
        check("head valid", user_valid, 1'b1);
        check("head word", user_data, 32'hc3a5_0f1e);
        user_ready = 1'b1;
        @(negedge clk);
        check("second word", user_data, 32'h1234_abcd);
        repeat (6) @(negedge clk);
        check("drained", user_valid, 1'b0);
    endtask
    task automatic t_float();
        logic [31:0] d;
        logic o;
        u_jtap_scan_ctrl.pins(1'b0, 1'b1, 1'b0);
        u_jtap_scan_ctrl.tick(1'b1, 1'b1, o);
        check("float set", float_active, 1'b1);
        u_jtap_scan_ctrl.tick(1'b1, 1'b1, o);
        check("float tdo", o, 1'bz);
        u_jtap_scan_ctrl.scan(1'b0, '1, 32, d);
        check("scan ignored", d, 'z);
        check("scan released", scan_control, 1'b0);
        u_jtap_scan_ctrl.pins(1'b1, 1'b0, 1'b1);
        u_jtap_scan_ctrl.tick(1'b1, 1'b1, o);
        check("float clear", float_active, 1'b0);
    endtask
    initial begin
        repeat (5) @(negedge clk);
        reset_n = 1'b1;
        t_ident();
        t_user();
        t_float();
        conclude();
    end
    // The run needs about 15 us; this bound only cuts a hang short.
    initial begin
        #100000;
        err_count++;
        conclude();
    end
endmodule
